// ---- src/rhs_pins.sv ----
// host-facing pin logic of the radio: serial lines, handshakes, strap
// assumes pins are already synchronous to i_clk; pull-ups sit outside as
// undriven inputs are modelled by the pad as logic high
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - test strap low at reset forces 9600 baud, 8 data, no parity, 1 stop.
// - test mode ends only by a reset with the strap read high.
// - a low pulse on the external reset pin resets the whole block.
// - host bytes are commands while select is low, payload while high.
// - in-range output is low when synced as client, always low on server.
// - clear-to-send is low while more host data can be taken.
// - an undriven request-to-send reads high and blocks output if enabled.
// - every undriven input reads high.
// - test mode also sets a 3 ms idle timeout and default packet size.
// - with flow control on, output waits while request-to-send is high.
// - with select low, nothing goes to the radio but reception goes on.
module rhs_pins
   import rhs_pkg::*;
#(
   parameter int unsigned RX_DEPTH = 16
)(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_reset_n,
   input  wire logic              i_test_n,
   input  wire logic              i_rxd,
   output logic                   o_txd,
   input  wire logic              i_cmd_data,
   input  wire logic              i_rts_n,
   output logic                   o_cts_n,
   output logic                   o_in_range_n,
   input  wire logic              i_is_server,
   input  wire logic              i_synced,
   input  wire logic              i_rts_en,
   input  wire logic              i_rate_500k,
   input  wire rhs_frame_t        i_cfg_frame,
   input  wire logic [IDLE_W-1:0] i_cfg_idle,
   input  wire logic [7:0]        i_cfg_pkt,
   input  wire logic              i_buf_ready,
   output logic                   o_cmd_valid,
   output logic                   o_pay_valid,
   output logic [7:0]             o_host_byte,
   input  wire logic              i_radio_valid,
   input  wire logic [7:0]        i_radio_data,
   output logic                   o_radio_ready,
   output logic                   o_rf_tx_en,
   output logic                   o_test_mode,
   output logic [IDLE_W-1:0]      o_idle_cyc,
   output logic [7:0]             o_pkt_size,
   output logic                   o_rx_err
);
   logic             rst_all;
   logic             test_q, test_d;
   logic             arm_q, arm_d;
   rhs_frame_t       frame;
   rhs_state_t       rst_q, rst_d;
   logic [DIV_W-1:0] rcnt_q, rcnt_d;
   logic [2:0]       rbit_q, rbit_d;
   logic [7:0]       rsh_q, rsh_d;
   rhs_byte_t        out_q, out_d;
   logic             vld_q, vld_d;
   logic             err_q, err_d;
   logic             tx_ready;
   logic             tx_go;

   // external reset pin resets everything; floats high when unused
   assign rst_all = i_rst | ~i_reset_n;

   // strap caught at the first clock after reset release
   always_comb begin
      arm_d  = 1'b0;
      test_d = test_q;
      if (arm_q) test_d = ~i_test_n; // only here can test mode begin
   end

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         arm_q  <= 1'b1;
         test_q <= 1'b0;
      end else begin
         arm_q  <= arm_d;
         test_q <= test_d;
      end
   end

   // test mode overrides the stored framing
   always_comb begin
      frame = i_cfg_frame;
      if (test_q) begin
         frame.baud_div  = DIV_W'(TEST_BAUD_DIV);
         frame.parity_en = TEST_PARITY_EN;
         frame.stop_bits = TEST_STOP_BITS;
      end
   end

   // idle timeout and packet size forced in test mode
   assign o_test_mode = test_q;
   assign o_idle_cyc  = test_q ? IDLE_W'(TEST_IDLE_CYC) : i_cfg_idle;
   assign o_pkt_size  = test_q ? (i_rate_500k ? DEF_PKT_500K : DEF_PKT_280K)
                               : i_cfg_pkt;

   // receiver samples mid-bit; parity is not supported, framing only
   always_comb begin
      rst_d  = rst_q;
      rcnt_d = rcnt_q - DIV_W'(1);
      rbit_d = rbit_q;
      rsh_d  = rsh_q;
      out_d  = out_q;
      vld_d  = 1'b0;
      err_d  = 1'b0;
      unique case (rst_q)
         RHS_IDLE: if (!i_rxd) begin
            rst_d  = RHS_START;
            rcnt_d = frame.baud_div >> 1;
         end
         RHS_START: if (rcnt_q == '0) begin
            rst_d  = i_rxd ? RHS_IDLE : RHS_DATA; // glitch rejected
            rcnt_d = frame.baud_div - DIV_W'(1);
            rbit_d = 3'h0;
         end
         RHS_DATA: if (rcnt_q == '0) begin
            rsh_d  = {i_rxd, rsh_q[7:1]}; // lsb arrives first
            rcnt_d = frame.baud_div - DIV_W'(1);
            rbit_d = rbit_q + 3'h1;
            if (rbit_q == 3'h7) rst_d = RHS_STOP;
         end
         RHS_STOP: if (rcnt_q == '0) begin
            rst_d = RHS_IDLE;
            if (i_rxd) begin // stop must be high
               vld_d       = 1'b1;
               out_d.data  = rsh_q;
               out_d.is_cmd = ~i_cmd_data; // low selects command
            end else begin
               err_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         rst_q  <= RHS_IDLE;
         rcnt_q <= '0;
         rbit_q <= 3'h0;
         rsh_q  <= 8'h00;
         out_q  <= '0;
         vld_q  <= 1'b0;
         err_q  <= 1'b0;
      end else begin
         rst_q  <= rst_d;
         rcnt_q <= rcnt_d;
         rbit_q <= rbit_d;
         rsh_q  <= rsh_d;
         out_q  <= out_d;
         vld_q  <= vld_d;
         err_q  <= err_d;
      end
   end

   // route bytes by the select pin
   assign o_host_byte = out_q.data;
   assign o_cmd_valid = vld_q & out_q.is_cmd;
   assign o_pay_valid = vld_q & ~out_q.is_cmd;
   assign o_rx_err    = err_q;

   // no radio transmit while in command mode; reception unaffected
   assign o_rf_tx_en = i_cmd_data;

   // clear-to-send follows buffer room, active low
   assign o_cts_n = ~i_buf_ready;

   // in-range: synced client or any server drives low
   assign o_in_range_n = ~(i_is_server | i_synced);

   // output held off while flow control on and rts high
   assign tx_go         = i_radio_valid & ~(i_rts_en & i_rts_n);
   assign o_radio_ready = tx_ready & ~(i_rts_en & i_rts_n);

   rhs_uart_tx u_tx (
      .i_clk   (i_clk),
      .i_rst   (rst_all),
      .i_frame (frame),
      .i_valid (tx_go),
      .i_data  (i_radio_data),
      .o_ready (tx_ready),
      .o_txd   (o_txd)
   );

   // checks
   property p_test_sticky;
      @(posedge i_clk) disable iff (rst_all)
      !$past(arm_q) |-> $stable(test_q); // the strap edge itself is exempt
   endproperty
   a_test_sticky: assert property (p_test_sticky)
      else $error("test mode changed without reset");

   property p_test_baud;
      @(posedge i_clk) disable iff (rst_all)
      test_q |-> frame.baud_div == DIV_W'(TEST_BAUD_DIV) && !frame.parity_en
                 && frame.stop_bits == TEST_STOP_BITS;
   endproperty
   a_test_baud: assert property (p_test_baud)
      else $error("test framing not forced");

   property p_test_idle;
      @(posedge i_clk) disable iff (rst_all)
      test_q |-> o_idle_cyc == IDLE_W'(TEST_IDLE_CYC);
   endproperty
   a_test_idle: assert property (p_test_idle)
      else $error("test idle timeout wrong");

   property p_cmd_route;
      @(posedge i_clk) disable iff (rst_all)
      (rst_q == RHS_STOP && rcnt_q == '0 && i_rxd && !i_cmd_data)
      |=> o_cmd_valid && !o_pay_valid;
   endproperty
   a_cmd_route: assert property (p_cmd_route)
      else $error("command byte misrouted");

   property p_in_range;
      @(posedge i_clk) disable iff (rst_all)
      i_is_server |-> !o_in_range_n;
   endproperty
   a_in_range: assert property (p_in_range)
      else $error("server in-range not low");

   property p_cts;
      @(posedge i_clk) disable iff (rst_all)
      o_cts_n == !i_buf_ready;
   endproperty
   a_cts: assert property (p_cts)
      else $error("clear-to-send wrong");

   property p_rts_hold;
      @(posedge i_clk) disable iff (rst_all)
      (i_rts_en && i_rts_n && tx_ready) [*2] |-> o_txd;
   endproperty
   a_rts_hold: assert property (p_rts_hold)
      else $error("output sent while rts high");

   property p_rf_block;
      @(posedge i_clk) disable iff (rst_all)
      !i_cmd_data |-> !o_rf_tx_en;
   endproperty
   a_rf_block: assert property (p_rf_block)
      else $error("radio transmit in command mode");

   property p_start_bit;
      @(posedge i_clk) disable iff (rst_all)
      (tx_go && tx_ready) |=> !o_txd;
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("no start bit");
endmodule // rhs_pins
`default_nettype wire

// ---- src/rhs_pkg.sv ----
// package for the radio host serial pin block
// assumes a single 100 MHz clock and synchronous active-high reset
package rhs_pkg;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned TEST_BAUD      = 9600;
   localparam int unsigned DEF_BAUD_DIV   = CLK_HZ / TEST_BAUD;
   localparam int unsigned TEST_BAUD_DIV  = CLK_HZ / TEST_BAUD;
   localparam int unsigned TEST_IDLE_MS   = 3;
   localparam int unsigned TEST_IDLE_CYC  = (CLK_HZ / 1000) * TEST_IDLE_MS;
   localparam int unsigned DEF_IDLE_CYC   = TEST_IDLE_CYC;
   localparam int unsigned DATA_BITS      = 8;
   localparam int unsigned BIT_CNT_W      = 4;
   localparam int unsigned DIV_W          = 20;
   localparam int unsigned IDLE_W         = 20;
   localparam logic [1:0]  TEST_STOP_BITS = 2'h1;
   localparam logic        TEST_PARITY_EN = 1'h0;
   localparam logic [7:0]  DEF_PKT_280K   = 8'h40;
   localparam logic [7:0]  DEF_PKT_500K   = 8'h80;

   // serial framing actually in force
   typedef struct packed {
      logic [DIV_W-1:0] baud_div;
      logic             parity_en;
      logic [1:0]       stop_bits;
   } rhs_frame_t;

   // one byte with its meaning from the command/data select
   typedef struct packed {
      logic       is_cmd;
      logic [7:0] data;
   } rhs_byte_t;

   typedef enum logic [1:0] {
      RHS_IDLE  = 2'b00,
      RHS_START = 2'b01,
      RHS_DATA  = 2'b10,
      RHS_STOP  = 2'b11
   } rhs_state_t;
endpackage

// ---- src/rhs_uart_tx.sv ----
// serial transmitter toward the host, one start, lsb first, stop high
// assumes i_frame is stable while a byte is in flight
`timescale 1ns/100ps
`default_nettype none
module rhs_uart_tx
   import rhs_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire rhs_frame_t i_frame,
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   output logic            o_ready,
   output logic            o_txd
);
   rhs_state_t       st_q, st_d;
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic [2:0]       bit_q, bit_d;
   logic [7:0]       sh_q, sh_d;
   logic             txd_q, txd_d;
   logic [1:0]       stp_q, stp_d;
   logic             tick;

   // one enable per bit period from the divider
   assign tick    = (cnt_q == '0);
   assign o_ready = (st_q == RHS_IDLE);
   assign o_txd   = txd_q;

   // next state of the framer
   always_comb begin
      st_d  = st_q;
      sh_d  = sh_q;
      bit_d = bit_q;
      stp_d = stp_q;
      txd_d = txd_q;
      cnt_d = tick ? i_frame.baud_div - DIV_W'(1) : cnt_q - DIV_W'(1);
      unique case (st_q)
         RHS_IDLE: begin
            cnt_d = i_frame.baud_div - DIV_W'(1);
            txd_d = 1'b1;
            if (i_valid) begin
               sh_d  = i_data;
               st_d  = RHS_START;
               txd_d = 1'b0; // start bit low
            end
         end
         RHS_START: if (tick) begin
            st_d  = RHS_DATA;
            bit_d = 3'h0;
            txd_d = sh_q[0]; // lsb first
            sh_d  = {1'b0, sh_q[7:1]};
         end
         RHS_DATA: if (tick) begin
            if (bit_q == 3'h7) begin
               st_d  = RHS_STOP;
               stp_d = i_frame.stop_bits;
               txd_d = 1'b1; // stop bit high
            end else begin
               bit_d = bit_q + 3'h1;
               txd_d = sh_q[0];
               sh_d  = {1'b0, sh_q[7:1]};
            end
         end
         RHS_STOP: if (tick) begin
            if (stp_q <= 2'h1) st_d = RHS_IDLE;
            stp_d = stp_q - 2'h1;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q  <= RHS_IDLE;
         cnt_q <= '0;
         bit_q <= 3'h0;
         sh_q  <= 8'h00;
         txd_q <= 1'b1;
         stp_q <= 2'h1;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sh_q  <= sh_d;
         txd_q <= txd_d;
         stp_q <= stp_d;
      end
   end
endmodule // rhs_uart_tx
`default_nettype wire

// ---- test/rhs_host_model.sv ----
// host side model: serial sender toward the device and decoder of txd
// assumes the bench keeps div equal to the divider the device runs at
`timescale 1ns/100ps
`default_nettype none
module rhs_host_model (
   input  wire logic i_clk,
   input  wire logic i_txd,
   output logic      o_rxd,
   output logic      o_rts_n
);
   int unsigned div = 16;
   logic [7:0]  rx_q[$];
   logic [7:0]  b;

   // idle line and undriven rts sit high on their pull-ups
   initial begin
      o_rxd   = 1'b1;
      o_rts_n = 1'b1;
   end

   // rts held high stalls the device, low lets it send
   task automatic hold(input logic h);
      o_rts_n = h;
   endtask

   // f is {stop, data}: start low, lsb first, then stop
   task automatic send(input logic [8:0] f);
      logic [9:0] w;
      w = {f, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         #1 o_rxd = w[i];
         repeat (div - 1) @(posedge i_clk);
      end
      @(posedge i_clk);
      #1 o_rxd = 1'b1;
   endtask

   // mid-bit sampling; a bad stop leaves an unknown so it never matches
   always begin
      @(negedge i_txd);
      repeat (div / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (div) @(posedge i_clk);
         b[i] = i_txd;
      end
      repeat (div) @(posedge i_clk);
      rx_q.push_back(i_txd === 1'b1 ? b : 8'hxx);
   end
endmodule // rhs_host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench of the host pin block with a host model
// assumes a 100 MHz clock and a fast stored divider outside test mode
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rhs_pkg::*;
   logic              i_clk, i_rst, i_reset_n, i_test_n, i_rxd, o_txd;
   logic              i_cmd_data, i_rts_n, o_cts_n, o_in_range_n;
   logic              i_is_server, i_synced, i_rts_en, i_rate_500k;
   logic              i_buf_ready, o_cmd_valid, o_pay_valid, o_rx_err;
   logic              i_radio_valid, o_radio_ready, o_rf_tx_en;
   logic              o_test_mode;
   rhs_frame_t        i_cfg_frame;
   logic [IDLE_W-1:0] i_cfg_idle, o_idle_cyc;
   logic [7:0]        i_cfg_pkt, o_pkt_size, o_host_byte, i_radio_data;
   logic [8:0]        got_q[$];
   logic [7:0]        tx_q[$];
   logic [8:0]        e;
   int                error_cnt = 0, total_checks = 0, cyc = 0, errs = 0;
   int                seed = 32'h80a524ec, r;

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   rhs_pins #(.RX_DEPTH(16)) rhs_pins_inst (
      .i_clk, .i_rst, .i_reset_n, .i_test_n, .i_rxd, .o_txd, .i_cmd_data,
      .i_rts_n, .o_cts_n, .o_in_range_n, .i_is_server, .i_synced,
      .i_rts_en, .i_rate_500k, .i_cfg_frame, .i_cfg_idle, .i_cfg_pkt,
      .i_buf_ready, .o_cmd_valid, .o_pay_valid, .o_host_byte,
      .i_radio_valid, .i_radio_data, .o_radio_ready, .o_rf_tx_en,
      .o_test_mode, .o_idle_cyc, .o_pkt_size, .o_rx_err);
   rhs_host_model rhs_host_model_inst (
      .i_clk, .i_txd(o_txd), .o_rxd(i_rxd), .o_rts_n(i_rts_n));

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // reset by the core reset or the pin, strap held through the latch
   task automatic do_reset(input logic pin, input logic strap);
      i_test_n = strap;
      if (pin) i_reset_n = 1'b0;
      else i_rst = 1'b1;
      tick(20);
      i_rst = 1'b0;
      i_reset_n = 1'b1;
      tick(2);
   endtask

   // valid is left high so back-to-back bytes need no gap; ready is looked
   // at on the edge itself, so a byte is never taken twice
   task automatic radio(input logic [7:0] d);
      i_radio_valid = 1'b1;
      i_radio_data = d;
      for (int w = 0; w < 400; w++) begin
         @(posedge i_clk);
         if (o_radio_ready === 1'b1) break;
      end
      #1;
      tx_q.push_back(d);
   endtask

   task automatic drain();
      chk(rhs_host_model_inst.rx_q.size(), tx_q.size());
      while (tx_q.size() > 0 && rhs_host_model_inst.rx_q.size() > 0)
         chk(rhs_host_model_inst.rx_q.pop_front(), tx_q.pop_front());
      tx_q.delete();
      rhs_host_model_inst.rx_q.delete();
   endtask

   // pulse capture before the edge's updates land; also the hang guard
   always @(posedge i_clk) begin
      if (o_cmd_valid === 1'b1) got_q.push_back({1'b1, o_host_byte});
      if (o_pay_valid === 1'b1) got_q.push_back({1'b0, o_host_byte});
      if (o_rx_err === 1'b1) errs++;
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      i_reset_n = 1'b1;
      i_cmd_data = 1'b1;
      i_is_server = 1'b0; i_synced = 1'b0; i_rts_en = 1'b0;
      i_rate_500k = 1'b0; i_buf_ready = 1'b1; i_radio_valid = 1'b0;
      i_radio_data = 8'h00; i_cfg_idle = 20'h00123; i_cfg_pkt = 8'h20;
      i_cfg_frame = '{baud_div: 20'h00010, parity_en: 1'b0, stop_bits: 2'h1};
      do_reset(1'b0, 1'b1);
      chk(o_test_mode, 32'h0);
      chk(o_idle_cyc, i_cfg_idle);
      chk(o_pkt_size, i_cfg_pkt);
      for (int k = 0; k < 8; k++) begin
         {i_is_server, i_synced, i_buf_ready} = k[2:0];
         tick(1);
         chk(o_in_range_n, !(k[2] || k[1]));
         chk(o_cts_n, !k[0]);
      end
      // host sends only while cts is low, select alternating per byte
      for (int k = 0; k < 6; k++) begin
         i_cmd_data = k[0]; // both routes in every run
         tick(1);
         chk(o_rf_tx_en, i_cmd_data);
         r = $random(seed);
         e = {~i_cmd_data, r[7:0]};
         while (o_cts_n !== 1'b0) tick(1);
         rhs_host_model_inst.send({1'b1, e[7:0]});
         tick(20);
         chk(got_q.size(), 1);
         if (got_q.size() > 0) chk(got_q.pop_front(), e);
      end
      rhs_host_model_inst.send(9'h05a);
      tick(40);
      chk(errs, 1);
      chk(got_q.size(), 0);
      repeat (4) radio(8'($random(seed)));
      i_radio_valid = 1'b0;
      tick(250);
      drain();
      // flow control on and the host holding off; two stop bits from here
      i_cfg_frame.stop_bits = 2'h2;
      i_rts_en = 1'b1;
      rhs_host_model_inst.hold(1'b1);
      i_radio_valid = 1'b1;
      i_radio_data = 8'ha5;
      tick(100);
      chk(o_radio_ready, 32'h0);
      chk(o_txd, 32'h1);
      rhs_host_model_inst.hold(1'b0);
      radio(8'ha5);
      i_radio_valid = 1'b0;
      tick(170);
      chk(o_radio_ready, 32'h0);
      tick(7);
      chk(o_radio_ready, 32'h1);
      tick(80);
      drain();
      // strap low through a pin reset, then released without reset
      i_rate_500k = 1'b1;
      do_reset(1'b1, 1'b0);
      i_test_n = 1'b1;
      tick(5);
      chk(o_test_mode, 32'h1);
      chk(o_idle_cyc, TEST_IDLE_CYC);
      chk(o_pkt_size, DEF_PKT_500K);
      radio(8'hff);
      i_radio_valid = 1'b0;
      tick(100);
      chk(o_txd, 32'h0);
      tick(TEST_BAUD_DIV - 101);
      chk(o_txd, 32'h0);
      tick(1);
      chk(o_txd, 32'h1);
      i_rate_500k = 1'b0;
      do_reset(1'b0, 1'b0);
      chk(o_pkt_size, DEF_PKT_280K);
      do_reset(1'b0, 1'b1);
      chk(o_test_mode, 32'h0);
      chk(o_pkt_size, i_cfg_pkt);
      tick(300);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
